/* File: ccr_pkg.sv */
// Purpose: Constants for the chip configuration and channel index registers
// Assumes: Registers reached over a byte-wide serial-port register access
// Notes:   Identifier value is arbitrary
package ccr_pkg;
  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [12:0] CCR_OFF_SETUP   = 13'h0000; // Port setup
  localparam logic [12:0] CCR_OFF_IDENT   = 13'h0001; // Part identifier
  localparam logic [12:0] CCR_OFF_GRADE   = 13'h0002; // Speed grade
  localparam logic [12:0] CCR_OFF_CHUPPER = 13'h0004; // Channels H..E
  localparam logic [12:0] CCR_OFF_CHLOWER = 13'h0005; // Channels D..A
  localparam logic [12:0] CCR_OFF_UPDATE  = 13'h00FF; // Device update
  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int CCR_BIT_LSBF_HI  = 6; // Bit order, upper mirror
  localparam int CCR_BIT_SRST_HI  = 5; // Soft reset, upper mirror
  localparam int CCR_BIT_SRST_LO  = 2; // Soft reset, lower mirror
  localparam int CCR_BIT_LSBF_LO  = 1; // Bit order, lower mirror
  localparam int CCR_BIT_UPD_SPD  = 0; // Update speed mode
  localparam int CCR_GRADE_LSB    = 4; // Speed field low bit
  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [7:0] CCR_RST_SETUP   = 8'h18;
  localparam logic [7:0] CCR_RST_CHUPPER = 8'h0F;
  localparam logic [7:0] CCR_RST_CHLOWER = 8'h3F;
  localparam logic [1:0] CCR_RST_GRADE   = 2'h0; // 40 MSPS mode
  localparam logic [7:0] CCR_FIXED_LOWER = 8'h30; // Bits 5:4 read one
  localparam logic [7:0] CCR_IDENT_DEF   = 8'h5C; // Arbitrary value
  localparam int         CCR_NUM_CH      = 8;
endpackage : ccr_pkg

/* File: ccr_mirror.sv */
// Purpose: Combine two mirrored copies of a control bit in a written byte
// Assumes: Either copy alone is enough to set the bit
// Notes:   Plain combinational leaf
`timescale 1ns/1ps
`default_nettype none
module ccr_mirror
  import ccr_pkg::*;
(
  input  wire logic [7:0] byte_in,   // Written byte
  output logic            lsbf_out,  // Bit order request
  output logic            srst_out   // Soft reset request
);
  // ****************************************************************
  // Mirror merge
  // ****************************************************************
  // Either shift order lands one copy in place, so OR them
  always_comb begin
    lsbf_out = byte_in[CCR_BIT_LSBF_HI] | byte_in[CCR_BIT_LSBF_LO];
    srst_out = byte_in[CCR_BIT_SRST_HI] | byte_in[CCR_BIT_SRST_LO];
  end
endmodule : ccr_mirror
`default_nettype wire

/* File: ccr_regs.sv */
// Purpose: Chip configuration and channel index register bank
// Assumes: Serial port decoded upstream into byte write and read strobes
// Notes:   Soft reset self clears after one cycle; outputs registered
`timescale 1ns/1ps
`default_nettype none
module ccr_regs
  import ccr_pkg::*;
#(
  parameter logic [7:0] IDENT = CCR_IDENT_DEF // Arbitrary value
)(
  input  wire logic        clock_in,       // 50 MHz clock
  input  wire logic        reset_n_in,     // Sync reset, active low
  input  wire logic [12:0] addr_in,        // Register address
  input  wire logic        wr_en_in,       // Write strobe
  input  wire logic [7:0]  wr_data_in,     // Write data
  input  wire logic        rd_en_in,       // Read strobe
  output logic [7:0]       rd_data_out,    // Read data
  output logic             rd_valid_out,   // Read data valid
  output logic             lsb_first_out,  // Bit order mode
  output logic [1:0]       speed_mode_out, // Active speed mode
  output logic [7:0]       chan_sel_out,   // Channel H..A select
  output logic             soft_reset_out  // Soft reset pulse
);
  // ****************************************************************
  // State
  // ****************************************************************
  typedef enum logic [0:0] {CCR_IDLE, CCR_RESET} ccr_state_t;
  ccr_state_t state;            // Soft reset sequencing
  logic       lsbf;             // Stored bit order
  logic [1:0] grade_pend;       // Written speed field
  logic [3:0] ch_upper;         // Channels H..E
  logic [3:0] ch_lower;         // Channels D..A
  logic       w_lsbf;           // Decoded bit order from write
  logic       w_srst;           // Decoded soft reset from write
  logic       wr_setup;         // Setup register written

  // Shared address match used by both read and write paths
  function automatic logic ccr_hit(input logic [12:0] a,
                                   input logic [12:0] off);
    ccr_hit = (a == off);
  endfunction : ccr_hit

  ccr_mirror u_mirror (
    .byte_in  (wr_data_in),
    .lsbf_out (w_lsbf),
    .srst_out (w_srst)
  );

  assign wr_setup = wr_en_in && ccr_hit(addr_in, CCR_OFF_SETUP);

  // ****************************************************************
  // Soft reset sequencer
  // ****************************************************************
  // One cycle in CCR_RESET; the bits never read back as set
  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      state          <= CCR_IDLE;
      soft_reset_out <= 1'b0;
    end else begin
      case (state)
        CCR_IDLE: begin
          if (wr_setup && w_srst) begin
            state          <= CCR_RESET;
            soft_reset_out <= 1'b1;
          end
        end
        CCR_RESET: begin
          state          <= CCR_IDLE;
          soft_reset_out <= 1'b0;
        end
        default: begin
          state          <= CCR_IDLE;
          soft_reset_out <= 1'b0;
        end
      endcase
    end
  end

  // ****************************************************************
  // Bit order, excluded from soft reset
  // ****************************************************************
  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      lsbf <= 1'b0;
    end else if (wr_setup) begin
      lsbf <= w_lsbf;
    end
  end

  // ****************************************************************
  // Speed grade and channel index
  // ****************************************************************
  // Soft reset takes priority; a write in the same cycle is lost
  always_ff @(posedge clock_in) begin
    if (!reset_n_in || state == CCR_RESET) begin
      grade_pend     <= CCR_RST_GRADE;
      speed_mode_out <= CCR_RST_GRADE;
      ch_upper       <= CCR_RST_CHUPPER[3:0];
      ch_lower       <= CCR_RST_CHLOWER[3:0];
    end else if (wr_en_in) begin
      if (ccr_hit(addr_in, CCR_OFF_GRADE)) begin
        grade_pend <= wr_data_in[CCR_GRADE_LSB +: 2];
      end
      if (ccr_hit(addr_in, CCR_OFF_UPDATE) && wr_data_in[CCR_BIT_UPD_SPD])
      begin
        speed_mode_out <= grade_pend;
      end
      if (ccr_hit(addr_in, CCR_OFF_CHUPPER)) begin
        ch_upper <= wr_data_in[3:0];
      end
      if (ccr_hit(addr_in, CCR_OFF_CHLOWER)) begin
        ch_lower <= wr_data_in[3:0];
      end
    end
  end

  // ****************************************************************
  // Mirror registered outputs
  // ****************************************************************
  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      lsb_first_out <= 1'b0;
      chan_sel_out  <= {CCR_RST_CHUPPER[3:0], CCR_RST_CHLOWER[3:0]};
    end else begin
      lsb_first_out <= lsbf;
      chan_sel_out  <= {ch_upper, ch_lower};
    end
  end

  // ****************************************************************
  // Read path
  // ****************************************************************
  // Unmapped addresses read zero; identifier ignores writes
  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      rd_data_out  <= 8'h00;
      rd_valid_out <= 1'b0;
    end else begin
      rd_valid_out <= rd_en_in;
      if (rd_en_in) begin
        if (ccr_hit(addr_in, CCR_OFF_SETUP)) begin
          rd_data_out <= CCR_RST_SETUP
                       | {1'b0, lsbf, 4'h0, lsbf, 1'b0};
        end else if (ccr_hit(addr_in, CCR_OFF_IDENT)) begin
          rd_data_out <= IDENT;
        end else if (ccr_hit(addr_in, CCR_OFF_GRADE)) begin
          rd_data_out <= {2'b00, grade_pend, 4'h0};
        end else if (ccr_hit(addr_in, CCR_OFF_CHUPPER)) begin
          rd_data_out <= {4'h0, ch_upper};
        end else if (ccr_hit(addr_in, CCR_OFF_CHLOWER)) begin
          rd_data_out <= CCR_FIXED_LOWER | {4'h0, ch_lower};
        end else begin
          rd_data_out <= 8'h00;
        end
      end
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  property p_srst_clear;
    @(posedge clock_in) disable iff (!reset_n_in)
    soft_reset_out |=> !soft_reset_out;
  endproperty
  a_srst_clear: assert property (p_srst_clear)
    else $error("soft reset did not clear");

  property p_srst_defaults;
    @(posedge clock_in) disable iff (!reset_n_in)
    soft_reset_out |=> ##1 (chan_sel_out == 8'hFF && speed_mode_out == 2'h0);
  endproperty
  a_srst_defaults: assert property (p_srst_defaults)
    else $error("defaults not restored");

  property p_lsbf_keep;
    @(posedge clock_in) disable iff (!reset_n_in)
    (wr_setup && w_srst) |-> ##2 (lsb_first_out == $past(w_lsbf, 2));
  endproperty
  a_lsbf_keep: assert property (p_lsbf_keep)
    else $error("bit order wrong after setup write");

  property p_ident;
    @(posedge clock_in) disable iff (!reset_n_in)
    (rd_en_in && addr_in == CCR_OFF_IDENT) |=> rd_data_out == IDENT;
  endproperty
  a_ident: assert property (p_ident)
    else $error("identifier read wrong");

  property p_upper;
    @(posedge clock_in) disable iff (!reset_n_in)
    (wr_en_in && addr_in == CCR_OFF_CHUPPER && !soft_reset_out
     && state == CCR_IDLE)
    |-> ##2 chan_sel_out[7:4] == $past(wr_data_in[3:0], 2);
  endproperty
  a_upper: assert property (p_upper)
    else $error("upper channel select wrong");

  property p_lower;
    @(posedge clock_in) disable iff (!reset_n_in)
    (rd_en_in && addr_in == CCR_OFF_CHLOWER) |=> rd_data_out[5:4] == 2'b11;
  endproperty
  a_lower: assert property (p_lower)
    else $error("lower index fixed bits wrong");

  property p_speed_hold;
    @(posedge clock_in) disable iff (!reset_n_in)
    !(wr_en_in && addr_in == CCR_OFF_UPDATE) && state == CCR_IDLE
    |=> $stable(speed_mode_out);
  endproperty
  a_speed_hold: assert property (p_speed_hold)
    else $error("speed changed without update");

  property p_speed_def;
    @(posedge clock_in) disable iff (!reset_n_in)
    soft_reset_out |=> speed_mode_out == CCR_RST_GRADE;
  endproperty
  a_speed_def: assert property (p_speed_def)
    else $error("speed mode not at 40 MSPS default");

  c_srst:   cover property (@(posedge clock_in) soft_reset_out);
  c_update: cover property (@(posedge clock_in)
    wr_en_in && addr_in == CCR_OFF_UPDATE);
  c_ident:  cover property (@(posedge clock_in)
    rd_en_in && addr_in == CCR_OFF_IDENT);
endmodule : ccr_regs
`default_nettype wire

/* File: ccr_host_model.sv */
// Purpose: Host controller model driving the register access strobes
// Assumes: One byte per access, strobes launched after a rising edge
// Notes:   Data lines inverted once released so stale values never linger
`timescale 1ns/1ps
`default_nettype none
module ccr_host_model
  import ccr_pkg::*;
(
  input  wire logic        clock_in,     // Shared clock
  output logic [12:0]      addr_out,     // Register address
  output logic             wr_en_out,    // Write strobe
  output logic [7:0]       wr_data_out,  // Write data
  output logic             rd_en_out,    // Read strobe
  input  wire logic [7:0]  rd_data_in,   // Read data
  input  wire logic        rd_valid_in   // Read data valid
);
  // Idle bus at time zero
  initial begin
    addr_out    = 13'h0000;
    wr_en_out   = 1'b0;
    wr_data_out = 8'h00;
    rd_en_out   = 1'b0;
  end
  // One write pulse; data inverted after so nothing stale stays on it
  task automatic write_reg(input logic [12:0] a, input logic [7:0] d);
    @(posedge clock_in);
    addr_out    <= a;
    wr_data_out <= d;
    wr_en_out   <= 1'b1;
    @(posedge clock_in);
    wr_en_out   <= 1'b0;
    wr_data_out <= ~d;
  endtask : write_reg
  // One read pulse; answer taken 1 ns after the taking edge
  task automatic read_reg(input logic [12:0] a, output logic [7:0] d,
                          output logic v);
    @(posedge clock_in);
    addr_out  <= a;
    rd_en_out <= 1'b1;
    @(posedge clock_in);
    rd_en_out <= 1'b0;
    #1;
    v = rd_valid_in;
    d = rd_data_in;
  endtask : read_reg
  // Speed change needs the grade write followed by the update strobe
  task automatic select_speed(input logic [1:0] m);
    write_reg(CCR_OFF_GRADE, {2'b00, m, 4'h0});
    write_reg(CCR_OFF_UPDATE, 8'h01);
  endtask : select_speed
endmodule : ccr_host_model
`default_nettype wire

/* File: ccr_regs_tb_top.sv */
// Purpose: Self-checking bench for the configuration register bank
// Assumes: Integer model of every register kept beside the design
// Notes:   Cycle timing is guarded by the design's own assertions
`timescale 1ns/1ps
`default_nettype none
module ccr_regs_tb_top
  import ccr_pkg::*;
;
  logic clock = 1'b0, reset_n = 1'b0;
  logic [12:0] addr;
  logic wr_en, rd_en, rd_valid, lsb_first, soft_reset;
  logic [7:0] wr_data, rd_data, chan_sel, d;
  logic [1:0] speed_mode;
  int mismatches = 0, n_compared = 0, seed = 59486;
  int m_lsb, m_speed, m_grade, m_up, m_lo; // Behavioural model state
  logic [7:0] tbl [4] = '{8'h40, 8'h02, 8'h42, 8'h00};

  always #10 clock = ~clock; // 50 MHz

  ccr_regs ccr_regs_inst (.clock_in(clock), .reset_n_in(reset_n),
    .addr_in(addr), .wr_en_in(wr_en), .wr_data_in(wr_data),
    .rd_en_in(rd_en), .rd_data_out(rd_data), .rd_valid_out(rd_valid),
    .lsb_first_out(lsb_first), .speed_mode_out(speed_mode),
    .chan_sel_out(chan_sel), .soft_reset_out(soft_reset));
  ccr_host_model ccr_host_model_inst (.clock_in(clock), .addr_out(addr),
    .wr_en_out(wr_en), .wr_data_out(wr_data), .rd_en_out(rd_en),
    .rd_data_in(rd_data), .rd_valid_in(rd_valid));

  task automatic chk(string nm, int exp, logic [7:0] got);
    n_compared++;
    if (got !== exp[7:0]) begin
      mismatches++;
      $display("[ERR] %s expected %0h seen %0h", nm, exp[7:0], got);
    end
  endtask : chk
  task automatic rd_chk(logic [12:0] a, int exp);
    logic v;
    ccr_host_model_inst.read_reg(a, d, v);
    chk("rd_valid", 1, {7'd0, v});
    chk("rd_data", exp, d);
  endtask : rd_chk
  // Defaults restored by reset and soft reset alike
  function automatic void defaults();
    m_speed = 0; m_grade = 0; m_up = 15; m_lo = 15;
  endfunction : defaults
  // Idle, then compare every level output and every register
  task automatic check_all(string t);
    repeat (3) @(posedge clock);
    #1;
    chk("lsb_first", m_lsb, {7'd0, lsb_first});
    chk("speed_mode", m_speed, {6'd0, speed_mode});
    chk("chan_sel", m_up * 16 + m_lo, chan_sel);
    rd_chk(CCR_OFF_SETUP, m_lsb ? 8'h5A : 8'h18);
    rd_chk(CCR_OFF_IDENT, CCR_IDENT_DEF);
    rd_chk(CCR_OFF_GRADE, m_grade * 16);
    rd_chk(CCR_OFF_CHUPPER, m_up);
    rd_chk(CCR_OFF_CHLOWER, 8'h30 | m_lo);
    rd_chk(13'h0003, 0);
    $display("test %s done", t);
  endtask : check_all
  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : summarize

  // Watchdog well beyond the expected run length
  initial begin
    #400000;
    mismatches++;
    summarize();
  end

  initial begin
    m_lsb = 0;
    defaults();
    repeat (4) @(posedge clock);
    reset_n <= 1'b1;
    check_all("reset");
    ccr_host_model_inst.write_reg(CCR_OFF_IDENT, $random(seed));
    check_all("ident");
    for (int i = 0; i < 4; i++) begin
      m_up = $random(seed) & 15;
      m_lo = $random(seed) & 15;
      ccr_host_model_inst.write_reg(CCR_OFF_CHUPPER, m_up);
      ccr_host_model_inst.write_reg(CCR_OFF_CHLOWER, m_lo);
      check_all("index");
    end
    for (int m = 3; m >= 0; m--) begin
      m_grade = m;
      ccr_host_model_inst.write_reg(CCR_OFF_GRADE, m * 16);
      ccr_host_model_inst.write_reg(CCR_OFF_UPDATE, 8'h00);
      check_all("pending");
      m_speed = m;
      ccr_host_model_inst.write_reg(CCR_OFF_UPDATE, 8'h01);
      check_all("speed");
    end
    for (int i = 0; i < 4; i++) begin
      m_lsb = (tbl[i] != 0);
      ccr_host_model_inst.write_reg(CCR_OFF_SETUP, tbl[i]);
      check_all("order");
    end
    for (int i = 0; i < 2; i++) begin
      m_up = $random(seed) & 7;
      ccr_host_model_inst.write_reg(CCR_OFF_CHUPPER, m_up);
      ccr_host_model_inst.select_speed(2'd2);
      ccr_host_model_inst.write_reg(CCR_OFF_SETUP, i ? 8'h04 : 8'h60);
      #1;
      chk("soft_reset", 1, {7'd0, soft_reset});
      m_lsb = (i == 0);
      defaults();
      check_all("soft reset");
    end
    // Load non-default values, then a hard reset in mid-run
    m_up = $random(seed) & 7;
    m_lsb = 1;
    m_grade = 1;
    m_speed = 1;
    ccr_host_model_inst.write_reg(CCR_OFF_CHUPPER, m_up);
    ccr_host_model_inst.write_reg(CCR_OFF_SETUP, 8'h42);
    ccr_host_model_inst.select_speed(2'd1);
    check_all("before reset");
    @(posedge clock);
    reset_n <= 1'b0;
    repeat (2) @(posedge clock);
    reset_n <= 1'b1;
    m_lsb = 0;
    defaults();
    check_all("hard reset");
    ccr_host_model_inst.select_speed(2'd0);
    check_all("low speed");
    summarize();
  end
endmodule : ccr_regs_tb_top
`default_nettype wire
